// ==== rtl/iim_regbank.sv ====
`timescale 1ns/10ps
`include "iim_regs.svh"

module iim_regbank
    import iim_pkg::*;
(
    // clock and reset
    input  wire logic                      core_clk,
    input  wire logic                      rst,
    // avalon-mm slave
    input  wire logic [`IIM_ADDR_W-1:0]    avs_address,
    input  wire logic                      avs_read,
    input  wire logic                      avs_write,
    input  wire logic [`IIM_DATA_W-1:0]    avs_writedata,
    input  wire logic [3:0]                avs_byteenable,
    output logic      [`IIM_DATA_W-1:0]    avs_readdata,
    output logic                           avs_waitrequest,
    // context completion interrupts
    input  wire logic [`IIM_TX_CTX_N-1:0]  tx_ctx_irq,
    input  wire logic [`IIM_RX_CTX_N-1:0]  rx_ctx_irq,
    // reset sources for the bus management csrs
    input  wire logic                      global_reset_input,
    input  wire logic                      pci_bus_reset_input,
    input  wire logic                      bus_reset_1394,
    // summary interrupts to the main event register
    output logic                           iso_tx_summary_irq,
    output logic                           iso_rx_summary_irq,
    // bus management csr values
    output logic      [`IIM_BW_W-1:0]      bandwidth_available_csr,
    output logic      [`IIM_CHAN_W-1:0]    channels_available_high_csr
);

    // ---------------------------------------------------------------
    // helper functions
    // ---------------------------------------------------------------

    // byte enables widened to a bit mask
    function automatic logic [`IIM_DATA_W-1:0] be_mask(input logic [3:0] be);
        be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction : be_mask

    // address decode, shared by read and write paths
    function automatic iim_sel_t decode(input logic [`IIM_ADDR_W-1:0] a);
        case (a)
            `IIM_TX_FLAGS_SET:  decode = IIM_SEL_TXF_SET;
            `IIM_TX_FLAGS_CLR:  decode = IIM_SEL_TXF_CLR;
            `IIM_TX_ENABLE_SET: decode = IIM_SEL_TXE_SET;
            `IIM_TX_ENABLE_CLR: decode = IIM_SEL_TXE_CLR;
            `IIM_RX_FLAGS_SET:  decode = IIM_SEL_RXF_SET;
            `IIM_RX_FLAGS_CLR:  decode = IIM_SEL_RXF_CLR;
            `IIM_RX_ENABLE_SET: decode = IIM_SEL_RXE_SET;
            `IIM_RX_ENABLE_CLR: decode = IIM_SEL_RXE_CLR;
            `IIM_INIT_BW:       decode = IIM_SEL_BW;
            `IIM_INIT_CHAN_HI:  decode = IIM_SEL_CHAN;
            `IIM_SOFT_CTRL:     decode = IIM_SEL_SOFT;
            default:            decode = IIM_SEL_NONE;
        endcase
    endfunction : decode

    // ---------------------------------------------------------------
    // state and bus qualifiers
    // ---------------------------------------------------------------
    iim_state_t                st_reg;
    iim_state_t                st_next;
    iim_sel_t                  sel;
    logic                      wr_acc;
    logic                      rd_acc;
    logic [`IIM_DATA_W-1:0]    wr_ones;
    logic [`IIM_DATA_W-1:0]    wr_lanes;
    logic [`IIM_DATA_W-1:0]    wr_merged_chan;
    logic [`IIM_TX_CTX_N-1:0]  tx_rise;
    logic [`IIM_RX_CTX_N-1:0]  rx_rise;
    logic                      soft_reset;
    logic                      csr_load;

    // limitations worth knowing before this is reused:
    // - the three csr reload inputs are taken as already on this clock;
    //   a source from another domain must be synchronised outside
    // - a context interrupt held high at reset release reads as a fresh
    //   edge, since the edge detectors reset low
    // - a clear write and a hardware edge on one bit in one cycle
    //   leave the bit set, so no completion is ever lost
    // - the summaries are and-or of flops, with no extra register stage

    // one wait state: request seen, answered the next cycle
    assign sel             = decode(avs_address);
    assign avs_waitrequest = (avs_read | avs_write) & ~st_reg.ack;
    assign wr_acc          = avs_write & st_reg.ack;
    assign rd_acc          = avs_read & st_reg.ack;
    assign wr_lanes        = be_mask(avs_byteenable);
    assign wr_ones         = avs_writedata & wr_lanes;
    assign wr_merged_chan  = (st_reg.init_chan & ~wr_lanes) | wr_ones;

    // context interrupts come from logic on this clock, no synchroniser
    assign tx_rise = tx_ctx_irq & ~st_reg.tx_prev;
    assign rx_rise = rx_ctx_irq & ~st_reg.rx_prev;

    // software reset strobe: write one to bit 0 of the control word
    assign soft_reset = wr_acc && (sel == IIM_SEL_SOFT) && wr_ones[0];
    assign csr_load   = global_reset_input | pci_bus_reset_input | bus_reset_1394;

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        st_next         = st_reg;
        st_next.ack     = (avs_read | avs_write) & ~st_reg.ack;
        st_next.tx_prev = tx_ctx_irq;
        st_next.rx_prev = rx_ctx_irq;

        // clear writes first, so an edge in the same cycle still wins
        if (wr_acc) begin
            case (sel)
                IIM_SEL_TXF_SET: begin
                    st_next.tx_flags = st_reg.tx_flags | wr_ones[`IIM_TX_CTX_N-1:0];
                end
                IIM_SEL_TXF_CLR: begin
                    st_next.tx_flags = st_reg.tx_flags & ~wr_ones[`IIM_TX_CTX_N-1:0];
                end
                IIM_SEL_TXE_SET: begin
                    st_next.tx_mask = st_reg.tx_mask | wr_ones[`IIM_TX_CTX_N-1:0];
                end
                IIM_SEL_TXE_CLR: begin
                    st_next.tx_mask = st_reg.tx_mask & ~wr_ones[`IIM_TX_CTX_N-1:0];
                end
                IIM_SEL_RXF_SET: begin
                    st_next.rx_flags = st_reg.rx_flags | wr_ones[`IIM_RX_CTX_N-1:0];
                end
                IIM_SEL_RXF_CLR: begin
                    st_next.rx_flags = st_reg.rx_flags & ~wr_ones[`IIM_RX_CTX_N-1:0];
                end
                IIM_SEL_RXE_SET: begin
                    st_next.rx_mask = st_reg.rx_mask | wr_ones[`IIM_RX_CTX_N-1:0];
                end
                IIM_SEL_RXE_CLR: begin
                    st_next.rx_mask = st_reg.rx_mask & ~wr_ones[`IIM_RX_CTX_N-1:0];
                end
                IIM_SEL_BW: begin
                    // upper bits are not stored, so they stay zero
                    st_next.init_bw = (st_reg.init_bw & ~wr_lanes[`IIM_BW_W-1:0])
                                      | wr_ones[`IIM_BW_W-1:0];
                end
                IIM_SEL_CHAN: begin
                    st_next.init_chan = wr_merged_chan;
                end
                default: begin
                    st_next.ack = st_next.ack; // unmapped writes are dropped
                end
            endcase
        end

        // hardware edges set flags, winning over a clear in the same cycle
        st_next.tx_flags = st_next.tx_flags | tx_rise;
        st_next.rx_flags = st_next.rx_flags | rx_rise;

        // software reset restores the initial-value fields only
        if (soft_reset) begin
            st_next.init_bw   = `IIM_INIT_BW_RST;
            st_next.init_chan = `IIM_INIT_CHAN_HI_RST;
        end

        // any of the three resets reloads the bus management csrs;
        // a 1394 bus reset leaves the initial fields themselves alone
        if (csr_load) begin
            st_next.bw_csr   = st_reg.init_bw;
            st_next.chan_csr = st_reg.init_chan;
        end

        // read data is captured in the wait cycle and held for the answer
        st_next.rdata = `IIM_RDATA_ZERO;
        if (avs_read && !st_reg.ack) begin
            case (sel)
                IIM_SEL_TXF_SET: st_next.rdata[`IIM_TX_CTX_N-1:0] = st_reg.tx_flags;
                IIM_SEL_TXF_CLR: st_next.rdata[`IIM_TX_CTX_N-1:0] = st_reg.tx_flags & st_reg.tx_mask;
                IIM_SEL_TXE_SET,
                IIM_SEL_TXE_CLR: st_next.rdata[`IIM_TX_CTX_N-1:0] = st_reg.tx_mask;
                IIM_SEL_RXF_SET: st_next.rdata[`IIM_RX_CTX_N-1:0] = st_reg.rx_flags;
                IIM_SEL_RXF_CLR: st_next.rdata[`IIM_RX_CTX_N-1:0] = st_reg.rx_flags & st_reg.rx_mask;
                IIM_SEL_RXE_SET,
                IIM_SEL_RXE_CLR: st_next.rdata[`IIM_RX_CTX_N-1:0] = st_reg.rx_mask;
                IIM_SEL_BW:      st_next.rdata[`IIM_BW_W-1:0] = st_reg.init_bw;
                IIM_SEL_CHAN:    st_next.rdata = st_reg.init_chan;
                default:         st_next.rdata = `IIM_RDATA_ZERO;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    // undefined reset bits of flags and masks are taken as zero
    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_reg.tx_flags  <= `IIM_TX_FLAGS_RST;
            st_reg.tx_mask   <= `IIM_TX_ENABLE_RST;
            st_reg.tx_prev   <= `IIM_TX_FLAGS_RST;
            st_reg.rx_flags  <= `IIM_RX_FLAGS_RST;
            st_reg.rx_mask   <= `IIM_RX_ENABLE_RST;
            st_reg.rx_prev   <= `IIM_RX_FLAGS_RST;
            st_reg.init_bw   <= `IIM_INIT_BW_RST;
            st_reg.init_chan <= `IIM_INIT_CHAN_HI_RST;
            st_reg.bw_csr    <= `IIM_INIT_BW_RST;
            st_reg.chan_csr  <= `IIM_INIT_CHAN_HI_RST;
            st_reg.ack       <= 1'b0;
            st_reg.rdata     <= `IIM_RDATA_ZERO;
        end else begin
            st_reg <= st_next;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    // summaries are plain and-or of registered flags and masks
    assign iso_tx_summary_irq          = |(st_reg.tx_flags & st_reg.tx_mask);
    assign iso_rx_summary_irq          = |(st_reg.rx_flags & st_reg.rx_mask);
    assign avs_readdata                = st_reg.rdata;
    assign bandwidth_available_csr     = st_reg.bw_csr;
    assign channels_available_high_csr = st_reg.chan_csr;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    logic [`IIM_TX_CTX_N-1:0] tx_ones;
    logic [`IIM_RX_CTX_N-1:0] rx_ones;
    assign tx_ones = wr_ones[`IIM_TX_CTX_N-1:0];
    assign rx_ones = wr_ones[`IIM_RX_CTX_N-1:0];

    tx_mask_set_a: assert property (
        wr_acc && sel == IIM_SEL_TXE_SET |=> (st_reg.tx_mask & $past(tx_ones)) == $past(tx_ones)
    ) else $error("tx enable set write lost");

    rx_mask_clear_a: assert property (
        wr_acc && sel == IIM_SEL_RXE_CLR |=> (st_reg.rx_mask & $past(rx_ones)) == '0
    ) else $error("rx enable clear write lost");

    mask_read_a: assert property (
        rd_acc && (sel == IIM_SEL_TXE_SET || sel == IIM_SEL_TXE_CLR)
        |-> avs_readdata == {24'h000000, $past(st_reg.tx_mask)}
    ) else $error("tx enable read wrong");

    rx_edge_set_a: assert property (
        |rx_rise |=> (st_reg.rx_flags & $past(rx_rise)) == $past(rx_rise)
    ) else $error("rx edge did not set flag");

    rx_flag_hold_a: assert property (
        |(st_reg.rx_flags & ~st_next.rx_flags) |-> wr_acc && sel == IIM_SEL_RXF_CLR
    ) else $error("rx flag cleared without clear write");

    rx_clear_read_a: assert property (
        rd_acc && sel == IIM_SEL_RXF_CLR
        |-> avs_readdata == {28'h0000000, $past(st_reg.rx_flags) & $past(st_reg.rx_mask)}
    ) else $error("rx clear offset read wrong");

    rx_reserved_zero_a: assert property (
        rd_acc && sel == IIM_SEL_RXF_SET |-> avs_readdata[31:4] == 28'h0000000
    ) else $error("rx reserved bits not zero");

    bw_reset_a: assert property (
        $fell(rst) |-> st_reg.init_bw == `IIM_INIT_BW_RST && st_reg.init_chan == `IIM_INIT_CHAN_HI_RST
    ) else $error("initial fields bad after reset");

    csr_load_a: assert property (
        csr_load |=> bandwidth_available_csr == $past(st_reg.init_bw)
                     && channels_available_high_csr == $past(st_reg.init_chan)
    ) else $error("csr not loaded on reset source");

    tx_clear_read_a: assert property (
        rd_acc && sel == IIM_SEL_TXF_CLR
        |-> avs_readdata == {24'h000000, $past(st_reg.tx_flags) & $past(st_reg.tx_mask)}
    ) else $error("tx clear offset read wrong");

    rx_summary_a: assert property (
        |(rx_rise & st_reg.rx_mask) && !(wr_acc && sel == IIM_SEL_RXE_CLR)
        |=> iso_rx_summary_irq
    ) else $error("rx summary missing after edge");

    answer_time_a: assert property (
        (avs_read || avs_write) && !st_reg.ack |=> !avs_waitrequest || !(avs_read || avs_write)
    ) else $error("answer not given after one wait");

    // read-back paths: data was captured the cycle before the answer, hence $past
    rx_mask_read_a: assert property (
        rd_acc && (sel == IIM_SEL_RXE_SET || sel == IIM_SEL_RXE_CLR)
        |-> avs_readdata == {28'h0000000, $past(st_reg.rx_mask)}
    ) else $error("rx enable read wrong");

    tx_reserved_zero_a: assert property (
        rd_acc && (sel == IIM_SEL_TXF_SET || sel == IIM_SEL_TXF_CLR)
        |-> avs_readdata[31:8] == 24'h000000
    ) else $error("tx reserved bits not zero");

    bw_upper_zero_a: assert property (
        rd_acc && sel == IIM_SEL_BW |-> avs_readdata[31:13] == 19'h00000
    ) else $error("bandwidth upper bits not zero");

    chan_read_a: assert property (
        rd_acc && sel == IIM_SEL_CHAN |-> avs_readdata == $past(st_reg.init_chan)
    ) else $error("channels high read wrong");

    read_idle_zero_a: assert property (
        !rd_acc |-> avs_readdata == `IIM_RDATA_ZERO
    ) else $error("read data not zero outside answer");

    // mask writes, the other direction of each register
    tx_mask_clear_a: assert property (
        wr_acc && sel == IIM_SEL_TXE_CLR |=> (st_reg.tx_mask & $past(tx_ones)) == '0
    ) else $error("tx enable clear write lost");

    rx_mask_set_a: assert property (
        wr_acc && sel == IIM_SEL_RXE_SET |=> (st_reg.rx_mask & $past(rx_ones)) == $past(rx_ones)
    ) else $error("rx enable set write lost");

    // event flags: set by edge or write, cleared only by a clear write
    tx_edge_set_a: assert property (
        |tx_rise |=> (st_reg.tx_flags & $past(tx_rise)) == $past(tx_rise)
    ) else $error("tx edge did not set flag");

    tx_flag_hold_a: assert property (
        |(st_reg.tx_flags & ~st_next.tx_flags) |-> wr_acc && sel == IIM_SEL_TXF_CLR
    ) else $error("tx flag cleared without clear write");

    rx_soft_set_a: assert property (
        wr_acc && sel == IIM_SEL_RXF_SET |=> (st_reg.rx_flags & $past(rx_ones)) == $past(rx_ones)
    ) else $error("rx set write lost");

    tx_summary_a: assert property (
        |(tx_rise & st_reg.tx_mask) && !(wr_acc && sel == IIM_SEL_TXE_CLR)
        |=> iso_tx_summary_irq
    ) else $error("tx summary missing after edge");

    // initial fields and their csr copies
    init_keep_a: assert property (
        bus_reset_1394 && !wr_acc
        |=> st_reg.init_bw == $past(st_reg.init_bw) && st_reg.init_chan == $past(st_reg.init_chan)
    ) else $error("bus reset disturbed initial fields");

    soft_reset_a: assert property (
        soft_reset
        |=> st_reg.init_bw == `IIM_INIT_BW_RST && st_reg.init_chan == `IIM_INIT_CHAN_HI_RST
    ) else $error("software reset did not restore fields");

    csr_stable_a: assert property (
        !csr_load |=> $stable(bandwidth_available_csr) && $stable(channels_available_high_csr)
    ) else $error("csr changed without reset source");

endmodule : iim_regbank

// ==== rtl/iim_regs.svh ====
`ifndef IIM_REGS_SVH
`define IIM_REGS_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define IIM_TX_FLAGS_SET     8'h90
`define IIM_TX_FLAGS_CLR     8'h94
`define IIM_TX_ENABLE_SET    8'h98
`define IIM_TX_ENABLE_CLR    8'h9C
`define IIM_RX_FLAGS_SET     8'hA0
`define IIM_RX_FLAGS_CLR     8'hA4
`define IIM_RX_ENABLE_SET    8'hA8
`define IIM_RX_ENABLE_CLR    8'hAC
`define IIM_INIT_BW          8'hB0
`define IIM_INIT_CHAN_HI     8'hB4
`define IIM_SOFT_CTRL        8'hB8

// ---------------------------------------------------------------
// field widths
// ---------------------------------------------------------------
`define IIM_TX_CTX_N         8
`define IIM_RX_CTX_N         4
`define IIM_BW_W             13
`define IIM_CHAN_W           32
`define IIM_ADDR_W           8
`define IIM_DATA_W           32

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define IIM_TX_FLAGS_RST     8'h00
`define IIM_TX_ENABLE_RST    8'h00
`define IIM_RX_FLAGS_RST     4'h0
`define IIM_RX_ENABLE_RST    4'h0
`define IIM_INIT_BW_RST      13'h1333
`define IIM_INIT_CHAN_HI_RST 32'hFFFFFFFF
`define IIM_RDATA_ZERO       32'h00000000

`endif

// ==== rtl/iim_pkg.sv ====
`include "iim_regs.svh"

package iim_pkg;

    // decoded register selection
    typedef enum {
        IIM_SEL_NONE, IIM_SEL_TXF_SET, IIM_SEL_TXF_CLR, IIM_SEL_TXE_SET, IIM_SEL_TXE_CLR,
        IIM_SEL_RXF_SET, IIM_SEL_RXF_CLR, IIM_SEL_RXE_SET, IIM_SEL_RXE_CLR,
        IIM_SEL_BW, IIM_SEL_CHAN, IIM_SEL_SOFT
    } iim_sel_t;

    // whole block state
    typedef struct packed {
        logic [`IIM_TX_CTX_N-1:0] tx_flags;
        logic [`IIM_TX_CTX_N-1:0] tx_mask;
        logic [`IIM_TX_CTX_N-1:0] tx_prev;
        logic [`IIM_RX_CTX_N-1:0] rx_flags;
        logic [`IIM_RX_CTX_N-1:0] rx_mask;
        logic [`IIM_RX_CTX_N-1:0] rx_prev;
        logic [`IIM_BW_W-1:0]     init_bw;
        logic [`IIM_CHAN_W-1:0]   init_chan;
        logic [`IIM_BW_W-1:0]     bw_csr;
        logic [`IIM_CHAN_W-1:0]   chan_csr;
        logic                     ack;
        logic [`IIM_DATA_W-1:0]   rdata;
    } iim_state_t;

endpackage : iim_pkg

// ==== dv/iim_regbank_tb.sv ====
`timescale 1ns/10ps
`include "iim_regs.svh"

// compare macro: counts every check, reports and counts each mismatch
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
    $display("[FAIL] %s expected %h seen %h", nm, e, g); end end

module iim_regbank_tb
    import iim_pkg::*;
;
    // ---------------------------------------------------------------
    // signals
    // ---------------------------------------------------------------
    logic        core_clk       = 1'b0;
    logic        rst            = 1'b1;
    logic [7:0]  avs_address    = 8'h00;
    logic        avs_read       = 1'b0;
    logic        avs_write      = 1'b0;
    logic [31:0] avs_writedata  = 32'h00000000;
    logic [3:0]  avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [7:0]  tx_ctx_irq     = 8'h00;
    logic [3:0]  rx_ctx_irq     = 4'h0;
    logic [2:0]  rst_src        = 3'h0;
    logic        iso_tx_summary_irq;
    logic        iso_rx_summary_irq;
    logic [12:0] bw_csr;
    logic [31:0] chan_csr;
    int          fail_count     = 0;
    int          n_tests        = 0;

    always #4 core_clk = ~core_clk;

    iim_regbank dut (
        .core_clk                    (core_clk),
        .rst                         (rst),
        .avs_address                 (avs_address),
        .avs_read                    (avs_read),
        .avs_write                   (avs_write),
        .avs_writedata               (avs_writedata),
        .avs_byteenable              (avs_byteenable),
        .avs_readdata                (avs_readdata),
        .avs_waitrequest             (avs_waitrequest),
        .tx_ctx_irq                  (tx_ctx_irq),
        .rx_ctx_irq                  (rx_ctx_irq),
        .global_reset_input          (rst_src[0]),
        .pci_bus_reset_input         (rst_src[1]),
        .bus_reset_1394              (rst_src[2]),
        .iso_tx_summary_irq          (iso_tx_summary_irq),
        .iso_rx_summary_irq          (iso_rx_summary_irq),
        .bandwidth_available_csr     (bw_csr),
        .channels_available_high_csr (chan_csr)
    );

    // ---------------------------------------------------------------
    // bus access tasks
    // ---------------------------------------------------------------
    // one idle edge before each request, so no signal is driven twice in a step;
    // waitrequest and read data are taken at the rising edge that accepts the request
    task automatic bus_xfer(input logic wr_en, input logic [7:0] a, input logic [31:0] d,
                            input logic [3:0] be, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge core_clk);
        avs_address    <= a;
        avs_write      <= wr_en;
        avs_read       <= ~wr_en;
        avs_writedata  <= d;
        avs_byteenable <= be;
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (n >= 20) begin
            fail_count++;
            $display("[FAIL] waitrequest expected 0 seen %b", avs_waitrequest);
        end
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus_xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be = 4'hF);
        logic [31:0] q;
        bus_xfer(1'b1, a, d, be, q);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus_xfer(1'b0, a, 32'h00000000, 4'hF, q);
        `CHK($sformatf("register %h", a), e, q)
    endtask : rd

    // summaries checked mid-cycle, after the last edge has settled
    task automatic sums(input logic etx, input logic erx);
        @(negedge core_clk);
        `CHK("tx summary", etx, iso_tx_summary_irq)
        `CHK("rx summary", erx, iso_rx_summary_irq)
    endtask : sums

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : wrap_up

    // ---------------------------------------------------------------
    // watchdog at 20000 cycles: the whole sequence needs well under 2000 cycles
    // ---------------------------------------------------------------
    initial begin
        #160000;
        fail_count++;
        $display("[FAIL] run length expected done seen hang");
        wrap_up();
    end

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        rd(`IIM_INIT_BW, 32'h00001333);
        rd(`IIM_INIT_CHAN_HI, 32'hFFFFFFFF);
        rd(`IIM_TX_ENABLE_SET, 32'h00000000);
        rd(`IIM_RX_FLAGS_SET, 32'h00000000);
        rd(`IIM_RX_ENABLE_SET, 32'h00000000);
        // receive mask set/clear, both offsets read the same
        wr(`IIM_RX_ENABLE_SET, 32'hFFFFFFF5);
        rd(`IIM_RX_ENABLE_SET, 32'h00000005);
        rd(`IIM_RX_ENABLE_CLR, 32'h00000005);
        wr(`IIM_RX_ENABLE_CLR, 32'h00000001);
        rd(`IIM_RX_ENABLE_SET, 32'h00000004);
        // context 2 rises and then stays high
        @(posedge core_clk);
        rx_ctx_irq <= 4'h4;
        rd(`IIM_RX_FLAGS_SET, 32'h00000004);
        sums(1'b0, 1'b1);
        rd(`IIM_RX_FLAGS_CLR, 32'h00000004);
        wr(`IIM_RX_FLAGS_CLR, 32'h00000000);
        rd(`IIM_RX_FLAGS_SET, 32'h00000004);
        wr(`IIM_RX_FLAGS_CLR, 32'h00000004);
        rd(`IIM_RX_FLAGS_SET, 32'h00000000);
        rx_ctx_irq <= 4'h0;
        // software set of every bit, reserved ones dropped
        wr(`IIM_RX_FLAGS_SET, 32'hFFFFFFFF);
        rd(`IIM_RX_FLAGS_SET, 32'h0000000F);
        rd(`IIM_RX_FLAGS_CLR, 32'h00000004);
        wr(`IIM_RX_FLAGS_CLR, 32'h00000004);
        sums(1'b0, 1'b0);
        rd(`IIM_RX_FLAGS_SET, 32'h0000000B);
        wr(`IIM_RX_FLAGS_CLR, 32'hFFFFFFFF);
        rd(`IIM_RX_FLAGS_SET, 32'h00000000);
        // transmit mask and flags
        wr(`IIM_TX_ENABLE_SET, 32'hFFFFFFFF);
        rd(`IIM_TX_ENABLE_SET, 32'h000000FF);
        rd(`IIM_TX_ENABLE_CLR, 32'h000000FF);
        wr(`IIM_TX_ENABLE_CLR, 32'h0000000F);
        rd(`IIM_TX_ENABLE_SET, 32'h000000F0);
        @(posedge core_clk);
        tx_ctx_irq <= 8'h81;
        @(posedge core_clk);
        tx_ctx_irq <= 8'h00;
        rd(`IIM_TX_FLAGS_SET, 32'h00000081);
        rd(`IIM_TX_FLAGS_CLR, 32'h00000080);
        sums(1'b1, 1'b0);
        wr(`IIM_TX_ENABLE_CLR, 32'h00000080);
        sums(1'b0, 1'b0);
        wr(`IIM_TX_FLAGS_SET, 32'hFFFFFF42);
        rd(`IIM_TX_FLAGS_SET, 32'h000000C3);
        wr(`IIM_TX_FLAGS_CLR, 32'h000000FF);
        rd(`IIM_TX_FLAGS_SET, 32'h00000000);
        // initial values and their copies
        wr(`IIM_INIT_BW, 32'hFFFFFFFF);
        rd(`IIM_INIT_BW, 32'h00001FFF);
        wr(`IIM_INIT_CHAN_HI, 32'h12345678);
        rd(`IIM_INIT_CHAN_HI, 32'h12345678);
        for (int i = 0; i < 3; i++) begin
            wr(`IIM_INIT_BW, 32'h00000100 + i);
            @(posedge core_clk);
            rst_src <= 3'h1 << i;
            @(posedge core_clk);
            rst_src <= 3'h0;
            @(negedge core_clk);
            `CHK("bandwidth csr", 13'h0100 + 13'(i), bw_csr)
            `CHK("channels csr", 32'h12345678, chan_csr)
            rd(`IIM_INIT_BW, 32'h00000100 + i);
        end
        wr(`IIM_INIT_CHAN_HI, 32'h00000000, 4'h1);
        rd(`IIM_INIT_CHAN_HI, 32'h12345600);
        rd(8'hC0, 32'h00000000);
        wr(8'hC0, 32'hFFFFFFFF);
        rd(`IIM_INIT_BW, 32'h00000102);
        // software reset restores the initial fields
        wr(`IIM_SOFT_CTRL, 32'h00000001);
        rd(`IIM_INIT_BW, 32'h00001333);
        rd(`IIM_INIT_CHAN_HI, 32'hFFFFFFFF);
        // hardware reset in mid-run
        rst <= 1'b1;
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        @(negedge core_clk);
        `CHK("bandwidth csr", 13'h1333, bw_csr)
        `CHK("channels csr", 32'hFFFFFFFF, chan_csr)
        rd(`IIM_TX_ENABLE_SET, 32'h00000000);
        rd(`IIM_RX_ENABLE_CLR, 32'h00000000);
        wrap_up();
    end

endmodule : iim_regbank_tb
